/* src/wakeup_reset_control.sv */
// Wake-up, reset merging, start-up sequencing, brownout and test-mode select logic.
`timescale 1ns/100ps
module wakeup_reset_control (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and analog comparators.
  input wire logic reset_pin_n,
  input wire logic [7:0] wake_pin_n,
  input wire logic power_on_reset,
  input wire logic [3:0] supply_below_level,
  input wire logic watchdog_reset_req,
  // Wake events and nested_irq_controller enables.
  input wire logic [7:0] nested_irq_controller_enable_pins,
  input wire wakeup_reset_pkg::wake_events_t wake_events,
  input wire logic watchdog_fed,
  // Core controls and status outputs.
  output wakeup_reset_pkg::core_ctrl_t core_ctrl,
  output logic wake_request,
  output logic brownout_irq,
  output logic boundary_scan_mode,
  output logic swd_enable
);
  import wakeup_reset_pkg::*;

  // Software-visible configuration registers.
  logic [7:0] pin_start_logic_enable;
  logic [7:0] periph_start_logic_enable;
  logic [4:0] brownout_control_reg;
  logic [1:0] sleep_power_config;
  logic [2:0] watchdog_mode_reg;
  logic lowpower_osc_clock_enable;
  logic [1:0] wake_timer_control;
  logic [7:0] wake_pin_enable_reg;
  logic [3:0] periph_cfg_reg;

  // Mode, sequencer and reset-cause state.
  power_mode_t mode_reg;
  logic deep_pd_reg;
  seq_state_t seq_reg;
  logic [4:0] seq_cnt_reg;
  logic [1:0] reset_cause_reg;

  // Two-stage synchronisers for pins and analog levels.
  // Pin and comparator inputs settle on no clock of ours, so nothing reads them raw.
  // The reset pin and power-on paths carry extra stages; the added latency is harmless.
  logic [1:0] rpin_s1, rpin_s2;
  logic [7:0] wpin_s1, wpin_s2;
  logic [3:0] lvl_s1, lvl_s2;
  logic [1:0] por_s1, por_s2;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rpin_s1 <= 2'h3;
      rpin_s2 <= 2'h3;
      wpin_s1 <= 8'hff;
      wpin_s2 <= 8'hff;
      lvl_s1 <= 4'h0;
      lvl_s2 <= 4'h0;
      por_s1 <= 2'h0;
      por_s2 <= 2'h0;
    end else begin
      rpin_s1 <= {rpin_s1[0], reset_pin_n};
      rpin_s2 <= {rpin_s2[0], rpin_s1[1]};
      wpin_s1 <= wake_pin_n;
      wpin_s2 <= wpin_s1;
      lvl_s1 <= supply_below_level;
      lvl_s2 <= lvl_s1;
      por_s1 <= {por_s1[0], power_on_reset};
      por_s2 <= {por_s2[0], por_s1[1]};
    end
  end

  // The pin path ends in rpin_s2[0]; one low sample there resets the device.
  // A single 8 ns sample covers the shortest legal pulse, so no glitch filter is added.
  // Noise shorter than a clock period can therefore still be caught as a reset.
  logic pin_low;
  assign pin_low = ~rpin_s2[0];

  // Brownout levels: index 0 is the reset comparator, 1..3 interrupt levels.
  // Level select zero turns the interrupt off, so reset-only use needs no mask.
  logic bod_irq_lvl;
  logic bod_rst_lvl;
  assign bod_irq_lvl = lvl_s2[brownout_control_reg[BC_IRQ_LVL_LSB +: 2]] &
                       (brownout_control_reg[BC_IRQ_LVL_LSB +: 2] != 2'h0);
  assign bod_rst_lvl = lvl_s2[0] & brownout_control_reg[BC_RST_EN];

  logic any_reset;
  assign any_reset = pin_low | watchdog_reset_req | por_s2[0] | bod_rst_lvl;

  // Wake sources, each gated by its own enables.
  // Each source is gated in isolation; the mode case below picks which ones count.
  logic deep_mode;
  logic wake_pins, wake_bod_irq, wake_bod_rst, wake_wdog_irq, wake_wdog_rst;
  logic wake_wkt, wake_serial, wake_touch, wake_dpd;
  assign deep_mode = (mode_reg == MODE_DEEP_SLEEP) | (mode_reg == MODE_POWER_DOWN);
  assign wake_pins = |(wake_events.pin_irq & nested_irq_controller_enable_pins & pin_start_logic_enable);
  assign wake_bod_irq = bod_irq_lvl & periph_start_logic_enable[P_BOD] &
                        wake_events.bod_irq & sleep_power_config[SP_BOD];
  assign wake_bod_rst = bod_rst_lvl & sleep_power_config[SP_BOD];
  assign wake_wdog_irq = wake_events.wdog_irq & watchdog_mode_reg[WM_EN] & watchdog_fed &
                         watchdog_mode_reg[WM_IRQ_EN] & periph_start_logic_enable[P_WDOG] &
                         sleep_power_config[SP_LOWPOWER_OSC];
  // The watchdog request doubles as its wake event; no separate flag is kept.
  // watchdog reset wake
  assign wake_wdog_rst = watchdog_reset_req & watchdog_mode_reg[WM_EN] &
                         watchdog_mode_reg[WM_RST_EN] & sleep_power_config[SP_LOWPOWER_OSC];
  assign wake_wkt = wake_events.wkt_timeout & lowpower_osc_clock_enable &
                    wake_timer_control[WT_LPCLK_SEL] & wake_timer_control[WT_STARTED] &
                    periph_start_logic_enable[P_WKT];
  assign wake_serial = wake_events.serial_irq & periph_cfg_reg[PC_SERIAL_SLAVE] &
                       periph_cfg_reg[PC_SERIAL_EXTCLK] & periph_start_logic_enable[P_SERIAL];
  assign wake_touch = wake_events.touch_irq & periph_cfg_reg[PC_TOUCH_IRQ_EN] &
                      periph_cfg_reg[PC_TOUCH_LOWPOWER_OSC] & periph_start_logic_enable[P_TOUCH];
  // Wake pins are active low; a pulled-up idle pin never wakes.
  // wake pin enable
  assign wake_dpd = |(~wpin_s2 & wake_pin_enable_reg);

  // Deep power-down listens only to the wake pins; every other source is unpowered there.
  // combine wake terms
  logic wake_now;
  always_comb begin
    wake_now = 1'b0;
    if (deep_pd_reg) begin
      wake_now = wake_dpd;
    end else begin
      case (mode_reg)
        MODE_SLEEP: wake_now = wake_events.any_nested_irq_controller_irq;
        MODE_DEEP_SLEEP, MODE_POWER_DOWN: begin
          wake_now = wake_pins | wake_bod_irq | wake_bod_rst | wake_wdog_irq |
                     wake_wdog_rst | wake_wkt | wake_serial | wake_touch;
        end
        default: wake_now = 1'b0;
      endcase
    end
  end

  // A reset source seen mid-sequence restarts it from the hold state.
  // The oscillator and flash counts are chosen, not measured; adjust them for real parts.
  // The counter is five bits wide, enough for both phase counts.
  // reset start sequencer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seq_reg <= SEQ_HOLD;
      seq_cnt_reg <= 5'h00;
    end else if (any_reset) begin
      seq_reg <= SEQ_HOLD;
      seq_cnt_reg <= 5'h00;
    end else begin
      case (seq_reg)
        SEQ_HOLD: begin
          seq_reg <= SEQ_OSC;
          seq_cnt_reg <= 5'h00;
        end
        SEQ_OSC: begin
          seq_cnt_reg <= seq_cnt_reg + 5'h01;
          if (seq_cnt_reg == 5'(OSC_START_CYC - 1)) begin
            seq_reg <= SEQ_FLASH;
            seq_cnt_reg <= 5'h00;
          end
        end
        SEQ_FLASH: begin
          seq_cnt_reg <= seq_cnt_reg + 5'h01;
          if (seq_cnt_reg == 5'(FLASH_INIT_CYC - 1)) begin
            seq_reg <= SEQ_RUN;
          end
        end
        SEQ_RUN: seq_reg <= SEQ_RUN;
        default: seq_reg <= SEQ_HOLD;
      endcase
    end
  end

  // Internal reset: held while sequencing, so the configuration and mode registers below reload their values.
  // Writes during this window are dropped silently, since the reload would undo them anyway.
  logic in_reset;
  assign in_reset = seq_reg != SEQ_RUN;

  // Last reset cause: 0 pin, 1 watchdog, 2 power-on, 3 brownout.
  // Power-on ranks first because it also explains every later reset seen while supply ramps.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reset_cause_reg <= 2'h2;
    end else if (por_s2[0]) begin
      reset_cause_reg <= 2'h2;
    end else if (bod_rst_lvl) begin
      reset_cause_reg <= 2'h3;
    end else if (watchdog_reset_req) begin
      reset_cause_reg <= 2'h1;
    end else if (pin_low) begin
      reset_cause_reg <= 2'h0;
    end
  end

  // APB register writes; zero-wait, one access phase per transfer.
  // Writes to the status word and unmapped offsets fall to the default and change nothing.
  // Upper data bits of each narrow register are ignored and read back as zero.
  logic apb_wr;
  assign apb_wr = psel & penable & pwrite & ~in_reset;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_start_logic_enable <= RST_ZERO[7:0];
      periph_start_logic_enable <= RST_ZERO[7:0];
      brownout_control_reg <= RST_BROWNOUT_CTRL[4:0];
      sleep_power_config <= RST_ZERO[1:0];
      watchdog_mode_reg <= RST_ZERO[2:0];
      lowpower_osc_clock_enable <= 1'b0;
      wake_timer_control <= RST_ZERO[1:0];
      wake_pin_enable_reg <= RST_ZERO[7:0];
      periph_cfg_reg <= RST_ZERO[3:0];
    end else if (in_reset) begin
      pin_start_logic_enable <= RST_ZERO[7:0];
      periph_start_logic_enable <= RST_ZERO[7:0];
      brownout_control_reg <= RST_BROWNOUT_CTRL[4:0];
      sleep_power_config <= RST_ZERO[1:0];
      watchdog_mode_reg <= RST_ZERO[2:0];
      lowpower_osc_clock_enable <= 1'b0;
      wake_timer_control <= RST_ZERO[1:0];
      wake_pin_enable_reg <= RST_ZERO[7:0];
      periph_cfg_reg <= RST_ZERO[3:0];
    end else if (apb_wr) begin
      case (paddr)
        OFS_PIN_START: pin_start_logic_enable <= pwdata[7:0];
        OFS_PERIPH_START: periph_start_logic_enable <= pwdata[7:0];
        OFS_BROWNOUT_CTRL: brownout_control_reg <= pwdata[4:0];
        OFS_SLEEP_PWR: sleep_power_config <= pwdata[1:0];
        OFS_WDOG_MODE: watchdog_mode_reg <= pwdata[2:0];
        OFS_LOWPOWER_OSC_EN: lowpower_osc_clock_enable <= pwdata[0];
        OFS_WAKE_TIMER: wake_timer_control <= pwdata[1:0];
        OFS_WAKE_PIN_EN: wake_pin_enable_reg <= pwdata[7:0];
        OFS_PERIPH_CFG: periph_cfg_reg <= pwdata[3:0];
        default: pin_start_logic_enable <= pin_start_logic_enable;
      endcase
    end
  end

  // Power mode: software enters a mode, a wake returns to run.
  // A wake in the same cycle as a mode write wins, so a late event never leaves the core asleep.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_reg <= MODE_RUN;
      deep_pd_reg <= 1'b0;
    end else if (in_reset) begin
      mode_reg <= MODE_RUN;
      deep_pd_reg <= 1'b0;
    end else if (wake_now) begin
      mode_reg <= MODE_RUN;
      deep_pd_reg <= 1'b0;
    end else if (apb_wr && paddr == OFS_POWER_MODE) begin
      mode_reg <= power_mode_t'(pwdata[1:0]);
      deep_pd_reg <= pwdata[2];
    end
  end

  // Read mux and registered APB answer.
  // Status bit 0 repeats the interrupt level so a plain bit test needs no shift.
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      OFS_PIN_START: rd_mux = {24'h0, pin_start_logic_enable};
      OFS_PERIPH_START: rd_mux = {24'h0, periph_start_logic_enable};
      OFS_BROWNOUT_CTRL: rd_mux = {27'h0, brownout_control_reg};
      OFS_SLEEP_PWR: rd_mux = {30'h0, sleep_power_config};
      OFS_WDOG_MODE: rd_mux = {29'h0, watchdog_mode_reg};
      OFS_LOWPOWER_OSC_EN: rd_mux = {31'h0, lowpower_osc_clock_enable};
      OFS_WAKE_TIMER: rd_mux = {30'h0, wake_timer_control};
      OFS_WAKE_PIN_EN: rd_mux = {24'h0, wake_pin_enable_reg};
      OFS_POWER_MODE: rd_mux = {29'h0, deep_pd_reg, mode_reg};
      OFS_STATUS: rd_mux = {24'h0, reset_cause_reg, seq_reg, lvl_s2[0], bod_irq_lvl,
                            ~rpin_s2[0], 1'b0} | {31'h0, bod_irq_lvl};
      OFS_PERIPH_CFG: rd_mux = {28'h0, periph_cfg_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  // Answer comes one cycle after the setup phase, so every transfer has one access cycle.
  // Registering the answer adds no wait cycle to a transfer but keeps the read mux off the output.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Core controls and test-mode outputs.
  // Every control leaves a flip-flop, so the core sees no glitch while modes change.
  // Boot address is a constant; it is registered only to keep outputs on flip-flops.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      core_ctrl <= '{core_reset: 1'b1, osc_enable: 1'b1, flash_init: 1'b0,
                     core_clock_en: 1'b0, periph_clock_en: 1'b0, flash_standby: 1'b0,
                     analog_off: 1'b0, boot_addr: BOOT_VECTOR};
      wake_request <= 1'b0;
      brownout_irq <= 1'b0;
      boundary_scan_mode <= 1'b0;
      swd_enable <= 1'b0;
    end else begin
      core_ctrl.core_reset <= in_reset;
      core_ctrl.osc_enable <= 1'b1;
      core_ctrl.flash_init <= seq_reg == SEQ_FLASH;
      // Deep power-down also stops the core clock, even when mode_reg reads run.
      // clocks back first
      core_ctrl.core_clock_en <= ~in_reset & (((mode_reg == MODE_RUN) & ~deep_pd_reg) | wake_now);
      core_ctrl.periph_clock_en <= ~in_reset & (~deep_mode | wake_now) & ~deep_pd_reg;
      core_ctrl.flash_standby <= deep_mode | deep_pd_reg;
      core_ctrl.analog_off <= deep_mode | deep_pd_reg;
      core_ctrl.boot_addr <= BOOT_VECTOR;
      wake_request <= wake_now;
      brownout_irq <= bod_irq_lvl;
      boundary_scan_mode <= pin_low;
      swd_enable <= ~in_reset & ~pin_low;
    end
  end

endmodule

/* src/wakeup_reset_pkg.sv */
// Package with register map, field positions, reset values and timing for wakeup_reset_control.
package wakeup_reset_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFS_PIN_START = 8'h00;
  localparam logic [7:0] OFS_PERIPH_START = 8'h04;
  localparam logic [7:0] OFS_BROWNOUT_CTRL = 8'h08;
  localparam logic [7:0] OFS_SLEEP_PWR = 8'h0c;
  localparam logic [7:0] OFS_WDOG_MODE = 8'h10;
  localparam logic [7:0] OFS_LOWPOWER_OSC_EN = 8'h14;
  localparam logic [7:0] OFS_WAKE_TIMER = 8'h18;
  localparam logic [7:0] OFS_WAKE_PIN_EN = 8'h1c;
  localparam logic [7:0] OFS_POWER_MODE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_PERIPH_CFG = 8'h28;

  // Peripheral start-logic bit positions.
  localparam int P_BOD = 0;
  localparam int P_WDOG = 1;
  localparam int P_WKT = 2;
  localparam int P_SERIAL = 3;
  localparam int P_TOUCH = 4;

  // Brownout control fields.
  localparam int BC_RST_LVL_LSB = 0;
  localparam int BC_IRQ_LVL_LSB = 2;
  localparam int BC_RST_EN = 4;

  // Sleep power configuration: bit set keeps the block powered.
  localparam int SP_BOD = 0;
  localparam int SP_LOWPOWER_OSC = 1;

  // Watchdog mode fields.
  localparam int WM_EN = 0;
  localparam int WM_RST_EN = 1;
  localparam int WM_IRQ_EN = 2;

  // Wake timer control and peripheral configuration fields.
  localparam int WT_LPCLK_SEL = 0;
  localparam int WT_STARTED = 1;
  localparam int PC_SERIAL_SLAVE = 0;
  localparam int PC_SERIAL_EXTCLK = 1;
  localparam int PC_TOUCH_LOWPOWER_OSC = 2;
  localparam int PC_TOUCH_IRQ_EN = 3;

  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_BROWNOUT_CTRL = 32'h0000_0000;
  localparam logic [31:0] BOOT_VECTOR = 32'h0000_0000;

  // Timing.
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_PULSE_NS = 50;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_START_CYC = 16;
  localparam int FLASH_INIT_CYC = 8;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP_SLEEP = 2'b11,
    MODE_POWER_DOWN = 2'b10
  } power_mode_t;

  // Reset and start-up sequencer, Gray-coded along the normal path.
  typedef enum logic [1:0] {
    SEQ_HOLD = 2'b00,
    SEQ_OSC = 2'b01,
    SEQ_FLASH = 2'b11,
    SEQ_RUN = 2'b10
  } seq_state_t;

  // Wake events from peripherals and controller.
  typedef struct packed {
    logic [7:0] pin_irq;
    logic bod_irq;
    logic wdog_irq;
    logic wkt_timeout;
    logic serial_irq;
    logic touch_irq;
    logic any_nested_irq_controller_irq;
  } wake_events_t;

  // Core-facing reset and clock controls.
  typedef struct packed {
    logic core_reset;
    logic osc_enable;
    logic flash_init;
    logic core_clock_en;
    logic periph_clock_en;
    logic flash_standby;
    logic analog_off;
    logic [31:0] boot_addr;
  } core_ctrl_t;

endpackage

/* tb/pin_probe_model.sv */
// Model of the reset pin, the pulled-up wake pins and the test probe.
`timescale 1ns/100ps
module pin_probe_model #(
  // 250 us of power-up settling counted in 8 ns clock cycles.
  parameter int POWERUP_WAIT = 31250
) (
  // Clock.
  input wire logic sys_clk,
  // Requests.
  input wire logic probe_low_req,
  input wire logic [7:0] wake_low_req,
  // Pins.
  output logic reset_pin_n,
  output logic [7:0] wake_pin_n
);
  int up_cnt = 0;
  always @(posedge sys_clk) begin
    if (up_cnt < POWERUP_WAIT) up_cnt <= up_cnt + 1;
  end
  // One process owns both pins, from power-up onwards.
  initial begin
    reset_pin_n = 1'b1;
    wake_pin_n = 8'hff;
    forever begin
      @(posedge sys_clk);
      reset_pin_n <= !(probe_low_req && up_cnt >= POWERUP_WAIT);
      // Released wake pins return high through the external pull-ups.
      wake_pin_n <= ~wake_low_req;
    end
  end
endmodule

/* tb/tb_wakeup_reset_control.sv */
// Self-checking bench for the wake and reset controller.
`timescale 1ns/100ps
module tb_wakeup_reset_control;
  import wakeup_reset_pkg::*;
  typedef struct packed {
    logic [71:0] r;
    logic [2:0] md;
    logic [7:0] ne;
    wake_events_t ev;
    logic [7:0] wn;
    logic fed;
    logic exp;
  } row_t;
  localparam logic [7:0] OFS_LIST [9] = '{OFS_PIN_START, OFS_PERIPH_START,
    OFS_BROWNOUT_CTRL, OFS_SLEEP_PWR, OFS_WDOG_MODE, OFS_LOWPOWER_OSC_EN, OFS_WAKE_TIMER,
    OFS_WAKE_PIN_EN, OFS_PERIPH_CFG};
  localparam row_t ROWS [15] = '{
    '{72'h0, 3'h1, 8'h00, 14'h0001, 8'hff, 1'b0, 1'b1},
    '{72'h01_00_00_00_00_00_00_00_00, 3'h3, 8'h01, 14'h0040, 8'hff, 1'b0, 1'b1},
    '{72'h01_00_00_00_00_00_00_00_00, 3'h3, 8'h00, 14'h0040, 8'hff, 1'b0, 1'b0},
    '{72'h00_01_04_01_00_00_00_00_00, 3'h2, 8'h00, 14'h0020, 8'hff, 1'b0, 1'b1},
    '{72'h00_01_04_00_00_00_00_00_00, 3'h2, 8'h00, 14'h0020, 8'hff, 1'b0, 1'b0},
    '{72'h00_02_00_02_05_00_00_00_00, 3'h3, 8'h00, 14'h0010, 8'hff, 1'b1, 1'b1},
    '{72'h00_02_00_02_05_00_00_00_00, 3'h3, 8'h00, 14'h0010, 8'hff, 1'b0, 1'b0},
    '{72'h00_04_00_00_00_01_03_00_00, 3'h3, 8'h00, 14'h0008, 8'hff, 1'b0, 1'b1},
    '{72'h00_04_00_00_00_01_01_00_00, 3'h3, 8'h00, 14'h0008, 8'hff, 1'b0, 1'b0},
    '{72'h00_08_00_00_00_00_00_00_03, 3'h3, 8'h00, 14'h0004, 8'hff, 1'b0, 1'b1},
    '{72'h00_08_00_00_00_00_00_00_01, 3'h3, 8'h00, 14'h0004, 8'hff, 1'b0, 1'b0},
    '{72'h00_10_00_00_00_00_00_00_0c, 3'h2, 8'h00, 14'h0002, 8'hff, 1'b0, 1'b1},
    '{72'h00_10_00_00_00_00_00_00_08, 3'h2, 8'h00, 14'h0002, 8'hff, 1'b0, 1'b0},
    '{72'h00_00_00_00_00_00_00_01_00, 3'h4, 8'h00, 14'h0000, 8'hfe, 1'b0, 1'b1},
    '{72'h00_00_00_00_00_00_00_02_00, 3'h4, 8'h00, 14'h0000, 8'hfe, 1'b0, 1'b0}};
  logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, nested_irq_controller_enable_pins = 8'h00, wake_low_req = 8'h00, wake_pin_n;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [3:0] supply_below_level = 4'h0;
  logic power_on_reset = 1'b0, watchdog_reset_req = 1'b0, watchdog_fed = 1'b0;
  logic probe_low_req = 1'b0, pready, pslverr, rerr, w, reset_pin_n;
  logic wake_request, brownout_irq, boundary_scan_mode, swd_enable;
  wake_events_t wake_events = '0;
  core_ctrl_t core_ctrl;
  int miscompares = 0, samples_checked = 0, cyc = 0;

  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  wakeup_reset_control wakeup_reset_control_inst (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .wake_pin_n(wake_pin_n), .power_on_reset(power_on_reset),
    .supply_below_level(supply_below_level), .watchdog_reset_req(watchdog_reset_req),
    .nested_irq_controller_enable_pins(nested_irq_controller_enable_pins), .wake_events(wake_events),
    .watchdog_fed(watchdog_fed), .core_ctrl(core_ctrl), .wake_request(wake_request),
    .brownout_irq(brownout_irq), .boundary_scan_mode(boundary_scan_mode),
    .swd_enable(swd_enable));
  pin_probe_model pin_probe_model_inst (
    .sys_clk(sys_clk), .probe_low_req(probe_low_req), .wake_low_req(wake_low_req),
    .reset_pin_n(reset_pin_n), .wake_pin_n(wake_pin_n));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("Error at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_core(input logic v);
    int n;
    n = 0;
    while (core_ctrl.core_reset !== v && n < 100) begin
      n++;
      @(posedge sys_clk);
    end
    chk(core_ctrl.core_reset, v);
    repeat (2) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    wait_core(1'b0);
    for (int k = 0; k < 9; k++) begin
      apb(1'b0, OFS_LIST[k], 32'h0);
      chk(rdat, k == 2 ? RST_BROWNOUT_CTRL : RST_ZERO);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    for (int i = 0; i < 15; i++) begin
      for (int k = 0; k < 9; k++) apb(1'b1, OFS_LIST[k], {24'h0, ROWS[i].r[71-8*k -: 8]});
      nested_irq_controller_enable_pins <= ROWS[i].ne;
      watchdog_fed <= ROWS[i].fed;
      apb(1'b1, OFS_POWER_MODE, {29'h0, ROWS[i].md});
      repeat (2) @(posedge sys_clk);
      chk(core_ctrl.core_clock_en, 1'b0);
      if (ROWS[i].md == 3'h3) chk({core_ctrl.flash_standby, core_ctrl.analog_off}, 2'b11);
      wake_events <= ROWS[i].ev;
      wake_low_req <= ~ROWS[i].wn;
      // A brownout event means the supply sits below interrupt level one.
      supply_below_level <= {2'h0, ROWS[i].ev.bod_irq, 1'b0};
      w = 1'b0;
      repeat (8) begin
        @(posedge sys_clk);
        if (wake_request === 1'b1) w = 1'b1;
      end
      chk(w, ROWS[i].exp);
      wake_events <= '0;
      wake_low_req <= 8'h00;
      supply_below_level <= 4'h0;
      apb(1'b1, OFS_POWER_MODE, 32'h0);
    end
    apb(1'b1, OFS_PIN_START, 32'hff);
    probe_low_req <= 1'b1;
    // The probe holds off until its power-up wait is over.
    while (reset_pin_n !== 1'b0) @(posedge sys_clk);
    repeat (5) @(posedge sys_clk);
    chk({core_ctrl.core_reset, core_ctrl.osc_enable}, 2'b11);
    chk({boundary_scan_mode, swd_enable}, 2'b10);
    probe_low_req <= 1'b0;
    wait_core(1'b0);
    chk({boundary_scan_mode, swd_enable}, 2'b01);
    apb(1'b0, OFS_PIN_START, 32'h0);
    chk(rdat, RST_ZERO);
    for (int l = 1; l < 4; l++) begin
      apb(1'b1, OFS_BROWNOUT_CTRL, 32'(l << 2));
      supply_below_level <= 4'(1 << l);
      repeat (4) @(posedge sys_clk);
      chk(brownout_irq, 1'b1);
    end
    apb(1'b1, OFS_BROWNOUT_CTRL, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk(brownout_irq, 1'b0);
    supply_below_level <= 4'h1;
    repeat (4) @(posedge sys_clk);
    chk(core_ctrl.core_reset, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdat[3], 1'b1);
    apb(1'b1, OFS_BROWNOUT_CTRL, 32'h10);
    wait_core(1'b1);
    supply_below_level <= 4'h0;
    wait_core(1'b0);
    for (int s = 0; s < 2; s++) begin
      if (s == 0) watchdog_reset_req <= 1'b1;
      else power_on_reset <= 1'b1;
      @(posedge sys_clk);
      watchdog_reset_req <= 1'b0;
      power_on_reset <= 1'b0;
      wait_core(1'b1);
      wait_core(1'b0);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rdat[7:6], s == 0 ? 2'h1 : 2'h2);
    end
    tally_and_finish;
  end
endmodule

/* tb/wakeup_reset_control_sva.sv */
// Concurrent checks on the ports of the wake and reset controller.
`timescale 1ns/100ps
module wakeup_reset_checker (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Bus handshake.
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Reset sources.
  input wire logic reset_pin_n,
  input wire logic power_on_reset,
  input wire logic watchdog_reset_req,
  // Core side.
  input wire wakeup_reset_pkg::core_ctrl_t core_ctrl,
  input wire logic wake_request,
  input wire logic boundary_scan_mode,
  input wire logic swd_enable
);
  import wakeup_reset_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  AST_APB_READY:
    assert property (psel && !penable |=> pready && $past(psel)) else $error("no ready");
  AST_READY_ONE:
    assert property (pready |=> !pready) else $error("ready held");
  AST_ERR_ZERO:
    assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad refusal");
  AST_PIN_RST:
    assert property (!reset_pin_n |-> ##[1:5] core_ctrl.core_reset) else $error("pin reset");
  AST_POR_RST:
    assert property (power_on_reset |-> ##[1:5] core_ctrl.core_reset) else $error("por");
  AST_WDOG_RST:
    assert property (watchdog_reset_req |-> ##[1:4] core_ctrl.core_reset) else $error("wdog");
  AST_FLASH_FIRST:
    assert property ($fell(core_ctrl.core_reset) |-> $past(core_ctrl.flash_init)
      && core_ctrl.osc_enable) else $error("start order");
  AST_SWD_RESET:
    assert property (core_ctrl.core_reset [*2] |-> !swd_enable) else $error("swd in reset");
  AST_BSCAN_ON:
    assert property (!reset_pin_n [*5] |-> boundary_scan_mode) else $error("scan off");
  AST_BSCAN_OFF:
    assert property (reset_pin_n [*5] |-> !boundary_scan_mode) else $error("scan on");
  AST_WAKE_CLK:
    assert property (wake_request |-> core_ctrl.core_clock_en && !$past(wake_request))
      else $error("wake pulse");
  AST_BOOT:
    assert property (core_ctrl.boot_addr == BOOT_VECTOR) else $error("boot address");
endmodule

bind wakeup_reset_control wakeup_reset_checker wakeup_reset_checker_inst (
  .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
  .power_on_reset(power_on_reset), .watchdog_reset_req(watchdog_reset_req),
  .core_ctrl(core_ctrl), .wake_request(wake_request),
  .boundary_scan_mode(boundary_scan_mode), .swd_enable(swd_enable)
);
